// file: hdl/dlcs_top.v
// logger store control: apb registers, record buffer and card store sequencer
`timescale 1ns/1ns
`default_nettype none
`include "dlcs_regs.vh"
module dlcs_top #(
	parameter DW = 32,
	parameter AW = 1
) (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output wire pready,
	output wire pslverr,
	input wire card_detect,
	input wire params_loaded,
	input wire cyclic_mode,
	input wire sample_valid,
	input wire [DW-1:0] sample_data,
	output wire sample_ready,
	output wire card_wr_valid,
	output wire [DW-1:0] card_wr_data,
	input wire card_wr_ready,
	input wire [31:0] rtc_stamp,
	output reg card_store_start,
	output reg [31:0] store_stamp_q,
	input wire card_done,
	input wire card_fault,
	input wire [15:0] card_fault_code
);
	localparam ST_IDLE = 1'b0;
	localparam ST_STORE = 1'b1;
	localparam DEPTH = 1 << AW;

	// pin inputs: two flops, only the second stage is used
	reg [2:0] pin_meta_q;
	reg [2:0] pin_q;
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_meta_q <= 3'h0;
			pin_q <= 3'h0;
		end else begin
			pin_meta_q <= {cyclic_mode, params_loaded, card_detect};
			pin_q <= pin_meta_q;
		end
	end
	wire present = pin_q[0];
	wire pvalid = pin_q[1];
	wire cyclic = pin_q[2];

	reg rec_en_q;
	reg streq_q;
	reg streq_prev_q;
	reg [15:0] code_q;
	reg [31:0] limit_q;
	reg [31:0] count_q;
	reg state_q;
	reg err_q;
	reg [15:0] errcode_q;

	// apb decode; zero wait states
	wire setup = psel & ~penable;
	wire access = psel & penable;
	wire wr = access & pwrite;
	reg hit_rd;
	reg hit_wr;
	always @* begin
		if (paddr == `DLCS_STATUS_OFS || paddr == `DLCS_COUNT_OFS ||
			paddr == `DLCS_ERRCODE_OFS) begin
			hit_rd = 1'b1;
			hit_wr = 1'b0;
		end else if (paddr == `DLCS_CTRL_OFS || paddr == `DLCS_CODE_OFS ||
			paddr == `DLCS_LIMIT_OFS) begin
			hit_rd = 1'b1;
			hit_wr = 1'b1;
		end else begin
			hit_rd = 1'b0;
			hit_wr = 1'b0;
		end
	end
	assign pready = 1'b1;
	// writes to read-only or unmapped words are refused and flagged
	assign pslverr = access & (pwrite ? ~hit_wr : ~hit_rd);

	// limit counts only when a nonzero limit is set
	wire limit_hit = (limit_q != 32'h0) && (count_q >= limit_q);
	wire limit_flag = limit_hit | cyclic;
	wire storing = (state_q == ST_STORE);

	wire [31:0] status = {25'h0, streq_q, rec_en_q, pvalid, limit_flag,
		err_q, storing, present};
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0;
		end else if (setup) begin
			if (paddr == `DLCS_STATUS_OFS) begin
				prdata <= status;
			end else if (paddr == `DLCS_CTRL_OFS) begin
				prdata <= {30'h0, streq_q, rec_en_q};
			end else if (paddr == `DLCS_COUNT_OFS) begin
				prdata <= count_q;
			end else if (paddr == `DLCS_CODE_OFS) begin
				prdata <= {16'h0, code_q};
			end else if (paddr == `DLCS_ERRCODE_OFS) begin
				// error code reads zero unless the error flag stands
				prdata <= err_q ? {16'h0, errcode_q} : 32'h0;
			end else if (paddr == `DLCS_LIMIT_OFS) begin
				prdata <= limit_q;
			end else begin
				prdata <= 32'h0;
			end
		end
	end

	// two-entry record buffer
	reg [DW-1:0] mem [0:DEPTH-1];
	reg [AW:0] wp_q;
	reg [AW:0] rp_q;
	wire empty = (wp_q == rp_q);
	wire full = (wp_q[AW] != rp_q[AW]) && (wp_q[AW-1:0] == rp_q[AW-1:0]);
	// capture stalls the sampler when the buffer backs up, no record lost
	assign sample_ready = rec_en_q & pvalid & ~full;
	wire push = sample_valid & sample_ready;
	assign card_wr_valid = storing & ~empty;
	assign card_wr_data = mem[rp_q[AW-1:0]];
	wire pop = card_wr_valid & card_wr_ready;
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wp_q <= {(AW+1){1'b0}};
			rp_q <= {(AW+1){1'b0}};
		end else begin
			if (push) begin
				wp_q <= wp_q + 1'b1;
			end
			if (pop) begin
				rp_q <= rp_q + 1'b1;
			end
		end
	end
	always @(posedge pclk) begin
		if (push) begin
			mem[wp_q[AW-1:0]] <= sample_data;
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count_q <= 32'h0;
		end else if (push) begin
			count_q <= count_q + 32'h1;
		end
	end

	// software control; hardware never clears record-enable
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rec_en_q <= 1'b0;
			streq_q <= 1'b0;
			limit_q <= `DLCS_LIMIT_RST;
		end else if (wr && paddr == `DLCS_CTRL_OFS) begin
			rec_en_q <= pwdata[`DLCS_CT_RECEN];
			streq_q <= pwdata[`DLCS_CT_STREQ];
		end else if (wr && paddr == `DLCS_LIMIT_OFS) begin
			limit_q <= pwdata;
		end
	end

	wire start_ok = streq_q & ~streq_prev_q & ~storing & present &
		(code_q == `DLCS_CODE_STORE);
	wire fail = card_fault | ~present;
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			streq_prev_q <= 1'b0;
			state_q <= ST_IDLE;
			code_q <= `DLCS_CODE_RST;
			err_q <= 1'b0;
			errcode_q <= 16'h0;
			card_store_start <= 1'b0;
			store_stamp_q <= 32'h0;
		end else begin
			streq_prev_q <= streq_q;
			card_store_start <= 1'b0;
			// completion wins over a software write in the same cycle
			if (storing && card_done && !fail) begin
				code_q <= `DLCS_CODE_DONE;
			end else if (wr && paddr == `DLCS_CODE_OFS) begin
				code_q <= pwdata[15:0];
			end
			case (state_q)
			ST_IDLE: begin
				if (start_ok) begin
					state_q <= ST_STORE;
					err_q <= 1'b0;
					card_store_start <= 1'b1;
					// card names the file from this date/time stamp
					store_stamp_q <= rtc_stamp;
				end
			end
			ST_STORE: begin
				if (fail) begin
					state_q <= ST_IDLE;
					err_q <= 1'b1;
					errcode_q <= card_fault ? card_fault_code :
						`DLCS_ERR_REMOVED;
				end else if (card_done) begin
					state_q <= ST_IDLE;
				end
			end
			default: begin
				state_q <= ST_IDLE;
			end
			endcase
		end
	end
endmodule // dlcs_top
`default_nettype wire

// file: hdl/dlcs_regs.vh
// register map, field positions, reset values and codes of the logger store control
`ifndef DLCS_REGS_VH
`define DLCS_REGS_VH
`define DLCS_STATUS_OFS 12'h000
`define DLCS_CTRL_OFS 12'h004
`define DLCS_COUNT_OFS 12'h008
`define DLCS_CODE_OFS 12'h00c
`define DLCS_ERRCODE_OFS 12'h010
`define DLCS_LIMIT_OFS 12'h014
`define DLCS_ST_PRESENT 0
`define DLCS_ST_STORING 1
`define DLCS_ST_ERROR 2
`define DLCS_ST_LIMIT 3
`define DLCS_ST_PVALID 4
`define DLCS_ST_RECEN 5
`define DLCS_ST_STREQ 6
`define DLCS_CT_RECEN 0
`define DLCS_CT_STREQ 1
`define DLCS_CODE_STORE 16'h5aa5
`define DLCS_CODE_DONE 16'h0000
`define DLCS_CODE_RST 16'h0000
`define DLCS_LIMIT_RST 32'h0000_0000
`define DLCS_ERR_REMOVED 16'h0001
`endif

// file: verif/dlcs_chk.sv
// port assertions of the logger store control
`timescale 1ns/1ns
`default_nettype none
module dlcs_chk (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic pslverr,
	input wire logic params_loaded,
	input wire logic card_detect,
	input wire logic sample_ready,
	input wire logic card_wr_valid,
	input wire logic card_done,
	input wire logic card_fault,
	input wire logic card_store_start,
	input wire logic [31:0] store_stamp_q,
	input wire logic [31:0] rtc_stamp
);
	logic wa;
	assign wa = psel && penable && pwrite;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_end;
		card_done || card_fault;
	endsequence
	AST_ONE: assert property (card_store_start |=> !card_store_start)
		else $error("start");
	AST_CAUSE: assert property (card_store_start |->
		$past(wa) || $past(wa, 2) || $past(wa, 3)) else $error("cause");
	AST_PV: assert property (!params_loaded [*4] |-> !sample_ready)
		else $error("pv");
	AST_CARD: assert property (!card_detect [*4] |-> !card_store_start)
		else $error("card");
	AST_STAMP: assert property (card_store_start |->
		store_stamp_q == $past(rtc_stamp)) else $error("stamp");
	AST_RO: assert property (wa && paddr == 12'h008 |-> pslverr)
		else $error("ro");
	AST_CODE: assert property (wa && paddr == 12'h00c |-> !pslverr)
		else $error("code");
	AST_END: assert property (s_end |=> !card_wr_valid)
		else $error("end");
endmodule // dlcs_chk
bind dlcs_top dlcs_chk i_dlcs_chk (.*);
`default_nettype wire

// file: verif/dlcs_card_model.sv
// card model: slow word sink that ends a store
`timescale 1ns/1ns
`default_nettype none
module dlcs_card_model (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic start,
	input wire logic wr_valid,
	input wire logic fail,
	output logic wr_ready,
	output logic done,
	output logic fault
);
	logic busy;
	logic [4:0] t;
	int words;
	// takes every other cycle to stall the buffer
	assign wr_ready = busy && t[0];
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			busy <= 0;
			t <= 0;
			words <= 0;
			done <= 0;
			fault <= 0;
		end else begin
			done <= busy && t == 5'h1f && !fail;
			fault <= busy && t == 5'h1f && fail;
			t <= busy ? t + 5'h01 : 5'h00;
			if (wr_valid && wr_ready)
				words <= words + 1;
			if (start)
				busy <= 1;
			if (done || fault)
				busy <= 0;
		end
	end
endmodule // dlcs_card_model
`default_nettype wire

// file: verif/test_data_logger_card_store_control.sv
// self-checking bench of the logger store control
`timescale 1ns/1ns
`default_nettype none
module test_data_logger_card_store_control;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic card_detect = 0, params_loaded = 0, cyclic_mode = 0, fail = 0;
	logic sample_valid = 0, card_wr_ready, card_done, card_fault;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, sample_data = 0, rtc_stamp = 0, prdata;
	logic [31:0] rd, card_wr_data, store_stamp_q;
	logic [15:0] card_fault_code = 16'h00a7;
	logic pready, pslverr, sample_ready, card_wr_valid, card_store_start, er;
	int num_errors = 0, comparisons = 0, starts = 0, n, pops = 0;
	logic [31:0] got0 = 0, got1 = 0;
	dlcs_top i_dlcs_top (.*);
	dlcs_card_model i_dlcs_card_model (.clk(pclk), .rst_n(presetn),
		.start(card_store_start), .wr_valid(card_wr_valid), .fail(fail),
		.wr_ready(card_wr_ready), .done(card_done), .fault(card_fault));
	initial forever #20 pclk = ~pclk;
	always @(posedge pclk) begin
		rtc_stamp <= rtc_stamp + 32'h1;
		if (card_store_start === 1'b1)
			starts++;
		// first two words reaching the card, kept in arrival order
		if (card_wr_valid === 1'b1 && card_wr_ready === 1'b1) begin
			if (pops == 0)
				got0 <= card_wr_data;
			if (pops == 1)
				got1 <= card_wr_data;
			pops++;
		end
	end
	task chk(input string s, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			num_errors++;
			$display("Error %s expected %h seen %h", s, e, g);
		end
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		{psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
		@(posedge pclk);
		penable <= 1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		{psel, penable} <= 2'b00;
	endtask
	task store(input logic f);
		fail <= f;
		apb(1, 12'h00c, 32'h5aa5);
		apb(1, 12'h004, 32'h3);
		if (f) @(posedge card_fault); else @(posedge card_done);
		repeat (2) @(posedge pclk);
		apb(1, 12'h004, 32'h1);
		apb(0, 12'h000, 0);
		chk("storing", 0, rd[1]);
		chk("error", f, rd[2]);
		chk("rec_en", 1, rd[5]);
		apb(0, f ? 12'h010 : 12'h00c, 0);
		chk("code", f ? 32'ha7 : 32'h0, rd);
	endtask
	task t_idle;
		apb(0, 12'h000, 0);
		chk("status", 0, rd);
		card_detect <= 1;
		apb(1, 12'h008, 0);
		chk("ro write", 1, er);
		apb(0, 12'h000, 0);
		chk("present", 1, rd);
		cyclic_mode <= 1;
		repeat (3) @(posedge pclk);
		apb(0, 12'h000, 0);
		chk("cyclic", 32'h9, rd);
		cyclic_mode <= 0;
		repeat (3) @(posedge pclk);
	endtask
	task t_record;
		params_loaded <= 1;
		apb(1, 12'h004, 32'h1);
		apb(1, 12'h014, 32'h2);
		n = 0;
		sample_valid <= 1;
		sample_data <= 32'h11;
		repeat (8) begin
			@(posedge pclk);
			if (sample_ready === 1'b1) begin
				n++;
				sample_data <= 32'h22;
			end
		end
		sample_valid <= 0;
		chk("takes", 2, n);
		apb(0, 12'h008, 0);
		chk("count", 2, rd);
		apb(0, 12'h000, 0);
		chk("status", 32'h39, rd);
	endtask
	task t_bad;
		apb(1, 12'h00c, 32'h1234);
		apb(1, 12'h004, 32'h3);
		repeat (6) @(posedge pclk);
		apb(1, 12'h004, 32'h1);
		chk("starts", 0, starts);
	endtask
	task close_out;
		$display("comparisons %0d num_errors %0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	initial begin
		repeat (4) @(posedge pclk);
		presetn <= 1;
		t_idle();
		t_record();
		t_bad();
		store(0);
		chk("words", 2, i_dlcs_card_model.words);
		chk("word0", 32'h11, got0);
		chk("word1", 32'h22, got1);
		store(1);
		close_out();
	end
	initial begin
		#100000;
		num_errors++;
		close_out();
	end
endmodule // test_data_logger_card_store_control
`default_nettype wire
